// ==== src/asc_pkg.sv ====
/*
 * Package for the converter sequencing control: register offsets,
 * field positions, reset values, divider codes and state encodings.
 * Assumes an 8-bit special register bus with byte addresses.
 */
package asc_pkg;
    localparam logic [7:0] ASC_ADDR_RESULT_LOW  = 8'h20;
    localparam logic [7:0] ASC_ADDR_RESULT_HIGH = 8'h21;
    localparam logic [7:0] ASC_ADDR_CONTROL     = 8'h22;
    localparam logic [7:0] ASC_ADDR_CLOCK_SEL   = 8'h23;
    localparam logic [7:0] ASC_ADDR_IRQ_STATUS  = 8'h24;
    localparam logic [7:0] ASC_ADDR_IRQ_MASK    = 8'h25;

    localparam int ASC_CHAN_LSB    = 0;
    localparam int ASC_CHAN_MSB    = 2;
    localparam int ASC_PCFG_LSB    = 3;
    localparam int ASC_PCFG_MSB    = 5;
    localparam int ASC_PENDING_BIT = 6;
    localparam int ASC_START_BIT   = 7;
    localparam int ASC_CLKSEL_LSB  = 0;
    localparam int ASC_CLKSEL_MSB  = 1;
    localparam int ASC_TEST_BIT    = 7;

    localparam int ASC_RESULT_BITS = 9;
    localparam int ASC_NUM_CHAN    = 4;

    localparam logic [7:0] ASC_CONTROL_RESET   = 8'h00;
    localparam logic [7:0] ASC_CLOCK_SEL_RESET = 8'h00;
    localparam logic [7:0] ASC_ZERO_BYTE       = 8'h00;

    localparam logic [1:0] ASC_DIV2_CODE  = 2'h0;
    localparam logic [1:0] ASC_DIV8_CODE  = 2'h1;
    localparam logic [1:0] ASC_DIV32_CODE = 2'h2;
    localparam logic [4:0] ASC_DIV2_LAST  = 5'h01;
    localparam logic [4:0] ASC_DIV8_LAST  = 5'h07;
    localparam logic [4:0] ASC_DIV32_LAST = 5'h1F;

    localparam logic [3:0] ASC_CONV_CLOCKS = 4'hA;

    typedef enum logic [1:0] {
        ASC_IDLE     = 2'b00,
        ASC_ARMED    = 2'b01,
        ASC_CONVERT  = 2'b11,
        ASC_FINISH   = 2'b10
    } asc_state_t;
endpackage

// ==== src/asc_clk_div.sv ====
/*
 * Conversion clock enable: one-cycle pulse every 2, 8 or 32 system
 * clocks, chosen by the two-bit select code.
 * Assumes the select code is held steady during a conversion.
 */
`timescale 1ns/1ps
module asc_clk_div
    import asc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [1:0] div_sel,
    output logic            tick
);
    logic [4:0] count;
    logic [4:0] last;

    always_comb begin
        case (div_sel)
            ASC_DIV2_CODE:  last = ASC_DIV2_LAST;
            ASC_DIV8_CODE:  last = ASC_DIV8_LAST;
            ASC_DIV32_CODE: last = ASC_DIV32_LAST;
            default:        last = ASC_DIV32_LAST;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst || !run) begin
            count <= 5'h00;
            tick  <= 1'b0;
        end else if (count >= last) begin
            count <= 5'h00;
            tick  <= 1'b1;
        end else begin
            count <= count + 5'h01;
            tick  <= 1'b0;
        end
    end
endmodule

// ==== src/asc_sar.sv ====
/*
 * Successive-approximation sequencer: walks nine result bits MSB first,
 * one per conversion clock tick, using the comparator decision input.
 * Assumes the comparator settles within one conversion clock.
 */
`timescale 1ns/1ps
module asc_sar
    import asc_pkg::*;
#(
    parameter int BITS = ASC_RESULT_BITS
) (
    input  wire logic            core_clk,
    input  wire logic            rst,
    input  wire logic            clear,
    input  wire logic            go,
    input  wire logic            tick,
    input  wire logic            cmp_above,
    output logic [BITS-1:0]      trial,
    output logic                 done
);
    logic [BITS-1:0] probe;
    logic            busy;

    always_ff @(posedge core_clk) begin
        if (rst || clear) begin
            trial <= '0;
            probe <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else if (go) begin
            probe <= {1'b1, {(BITS-1){1'b0}}};
            trial <= {1'b1, {(BITS-1){1'b0}}};
            busy  <= 1'b1;
            done  <= 1'b0;
        end else if (busy && tick) begin
            // Keep or drop the trial bit, then try the next one down
            trial <= (cmp_above ? trial : (trial & ~probe)) | (probe >> 1);
            probe <= probe >> 1;
            if (probe[0]) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
        end else begin
            done <= 1'b0;
        end
    end
endmodule

// ==== src/asc_top.sv ====
/*
 * Converter sequencing control: control and clock registers, start
 * pulse protocol, pending flag, result bytes, interrupt and port B
 * analog assignment with converter power control.
 * Assumes a same-clock register port and an analog front end that
 * returns a comparator decision for the selected input.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Channel field codes 0-3 select analog input; top bit set is undefined.
// - Port config field sets how many low port B lines are analog.
// - Port config zero makes all lines digital, converter powered off.
// - Control bit 6 is pending flag: 1 while pending, 0 when done.
// - Start bit 7 sequence 0-1-0; falling edge launches conversion.
// - Start rising edge resets converter and sets pending flag.
// - Clock select codes give system clock divided by 2, 8, 32.
// - Clock register bits 2 to 6 always read zero.
// - At conversion end clear pending flag, set interrupt request.
// - High byte holds result bits 8-1; low byte bit 7 holds bit 0.
// - Analog-assigned port B lines lose digital function and pull-up.
module asc_top
    import asc_pkg::*;
#(
    parameter int LINES = ASC_NUM_CHAN
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_write,
    input  wire logic             reg_read,
    output logic [7:0]            reg_rdata,
    input  wire logic             cmp_above,
    output logic [1:0]            analog_sel,
    output logic                  converter_power,
    output logic [LINES-1:0]      port_b_analog,
    output logic [LINES-1:0]      port_b_digital_en,
    output logic [LINES-1:0]      port_b_pullup_en,
    output logic                  test_mode,
    output logic                  irq
);
    logic [7:0]                  converter_control;
    logic [7:0]                  converter_clock_select;
    logic [ASC_RESULT_BITS-1:0]  result;
    logic                        conv_irq_request;
    logic                        conv_irq_enable;
    logic                        cmp_meta;
    logic                        cmp_sync;
    asc_state_t                  state;
    asc_state_t                  next_state;
    logic                        tick;
    logic                        sar_done;
    logic [ASC_RESULT_BITS-1:0]  sar_trial;
    logic                        wr_ctrl;
    logic                        start_rise;
    logic                        start_fall;
    logic [2:0]                  pcfg;
    logic [LINES-1:0]            next_analog;
    logic                        wr_clock;
    logic                        wr_status;
    logic                        wr_mask;
    logic                        conv_end;
    logic                        sar_go;
    logic                        div_run;
    logic [1:0]                  chan_low;

    assign wr_ctrl    = reg_write && (reg_addr == ASC_ADDR_CONTROL);
    assign start_rise = wr_ctrl && reg_wdata[ASC_START_BIT]
                        && !converter_control[ASC_START_BIT];
    assign start_fall = wr_ctrl && !reg_wdata[ASC_START_BIT]
                        && converter_control[ASC_START_BIT];
    assign pcfg = converter_control[ASC_PCFG_MSB:ASC_PCFG_LSB];
    assign chan_low  = converter_control[ASC_CHAN_LSB+1:ASC_CHAN_LSB];
    assign wr_clock  = reg_write && (reg_addr == ASC_ADDR_CLOCK_SEL);
    assign wr_status = reg_write && (reg_addr == ASC_ADDR_IRQ_STATUS);
    assign wr_mask   = reg_write && (reg_addr == ASC_ADDR_IRQ_MASK);
    assign div_run   = (state == ASC_CONVERT);
    assign sar_go    = start_fall && (state == ASC_ARMED);
    // A restart in the finishing cycle wins over the completion
    assign conv_end  = div_run && sar_done && !start_rise;

    // Comparator crosses from the analog domain
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= cmp_above;
            cmp_sync <= cmp_meta;
        end
    end

    asc_clk_div u_div (
        .core_clk (core_clk),
        .rst      (rst),
        .run      (div_run),
        .div_sel  (converter_clock_select[ASC_CLKSEL_MSB:ASC_CLKSEL_LSB]),
        .tick     (tick)
    );

    asc_sar #(
        .BITS (ASC_RESULT_BITS)
    ) u_sar (
        .core_clk  (core_clk),
        .rst       (rst),
        .clear     (start_rise),
        .go        (sar_go),
        .tick      (tick),
        .cmp_above (cmp_sync),
        .trial     (sar_trial),
        .done      (sar_done)
    );

    always_comb begin
        next_state = state;
        case (state)
            ASC_IDLE:    if (start_rise) next_state = ASC_ARMED;
            ASC_ARMED:   if (start_fall) next_state = ASC_CONVERT;
            ASC_CONVERT: begin
                if (start_rise)    next_state = ASC_ARMED;
                else if (sar_done) next_state = ASC_FINISH;
            end
            ASC_FINISH:  next_state = start_rise ? ASC_ARMED : ASC_IDLE;
            default:     next_state = ASC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) state <= ASC_IDLE;
        else     state <= next_state;
    end

    // Control register: software fields plus hardware-owned pending flag
    always_ff @(posedge core_clk) begin
        if (rst) begin
            converter_control <= ASC_CONTROL_RESET;
        end else begin
            if (wr_ctrl) begin
                converter_control[ASC_START_BIT] <= reg_wdata[ASC_START_BIT];
                converter_control[ASC_PCFG_MSB:ASC_CHAN_LSB] <=
                    reg_wdata[ASC_PCFG_MSB:ASC_CHAN_LSB];
            end
            if (start_rise)
                converter_control[ASC_PENDING_BIT] <= 1'b1;
            else if (conv_end)
                converter_control[ASC_PENDING_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            converter_clock_select <= ASC_CLOCK_SEL_RESET;
        else if (wr_clock) begin
            converter_clock_select <= ASC_ZERO_BYTE;
            converter_clock_select[ASC_CLKSEL_MSB:ASC_CLKSEL_LSB] <=
                reg_wdata[ASC_CLKSEL_MSB:ASC_CLKSEL_LSB];
            converter_clock_select[ASC_TEST_BIT] <=
                reg_wdata[ASC_TEST_BIT];
        end
    end

    // Result loads with the pending flag clear
    always_ff @(posedge core_clk) begin
        if (rst)
            result <= '0;
        else if (conv_end)
            result <= sar_trial;
    end

    // Sticky request; a completion beats a same-cycle clear
    always_ff @(posedge core_clk) begin
        if (rst)
            conv_irq_request <= 1'b0;
        else if (conv_end)
            conv_irq_request <= 1'b1;
        else if (wr_status && reg_wdata[0])
            conv_irq_request <= 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            conv_irq_enable <= 1'b0;
        else if (wr_mask)
            conv_irq_enable <= reg_wdata[0];
    end

    always_ff @(posedge core_clk) begin
        if (rst) irq <= 1'b0;
        else     irq <= conv_irq_request && conv_irq_enable;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= ASC_ZERO_BYTE;
        end else if (reg_read) begin
            case (reg_addr)
                ASC_ADDR_RESULT_LOW:
                    reg_rdata <= {result[0], 7'h00};
                ASC_ADDR_RESULT_HIGH:
                    reg_rdata <= result[ASC_RESULT_BITS-1:1];
                ASC_ADDR_CONTROL:
                    reg_rdata <= converter_control;
                ASC_ADDR_CLOCK_SEL:
                    reg_rdata <= converter_clock_select;
                ASC_ADDR_IRQ_STATUS:
                    reg_rdata <= {7'h00, conv_irq_request};
                ASC_ADDR_IRQ_MASK:
                    reg_rdata <= {7'h00, conv_irq_enable};
                default:
                    reg_rdata <= ASC_ZERO_BYTE;
            endcase
        end else begin
            reg_rdata <= ASC_ZERO_BYTE;
        end
    end

    // Analog lines: codes 1-3 take lines from bit 0 up, top bit all
    always_comb begin
        next_analog = '0;
        if (pcfg[2])
            next_analog = '1;
        else
            for (int i = 0; i < LINES; i++)
                next_analog[i] = (i < int'(pcfg[1:0]));
    end

    // Port B line roles follow the configuration field
    always_ff @(posedge core_clk) begin
        if (rst) begin
            port_b_analog     <= '0;
            port_b_digital_en <= '1;
            port_b_pullup_en  <= '1;
        end else begin
            port_b_analog     <= next_analog;
            port_b_digital_en <= ~next_analog;
            port_b_pullup_en  <= ~next_analog;
        end
    end

    // Converter stays off while no line is analog
    always_ff @(posedge core_clk) begin
        if (rst) converter_power <= 1'b0;
        else     converter_power <= (pcfg != 3'h0);
    end

    // Top bit set is undefined; low two bits still drive the mux
    always_ff @(posedge core_clk) begin
        if (rst) analog_sel <= 2'h0;
        else     analog_sel <= chan_low;
    end

    always_ff @(posedge core_clk) begin
        if (rst) test_mode <= 1'b0;
        else     test_mode <= converter_clock_select[ASC_TEST_BIT];
    end
endmodule

// ==== tb/asc_top_sva.sv ====
/* Checker for the converter sequencing control, bound into asc_top.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module asc_chk
    import asc_pkg::*;
#(
    parameter int LINES = ASC_NUM_CHAN
) (
    input wire logic             core_clk,
    input wire logic             rst,
    input wire logic [7:0]       reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_write,
    input wire logic             reg_read,
    input wire logic [7:0]       reg_rdata,
    input wire logic             cmp_above,
    input wire logic [1:0]       analog_sel,
    input wire logic             converter_power,
    input wire logic [LINES-1:0] port_b_analog,
    input wire logic [LINES-1:0] port_b_digital_en,
    input wire logic [LINES-1:0] port_b_pullup_en,
    input wire logic             test_mode,
    input wire logic             irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [7:0] ctrl_q;
    logic [7:0] clk_q;
    logic       mask_q;

    // Shadow copies of the software-written registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= ASC_CONTROL_RESET;
            clk_q  <= ASC_CLOCK_SEL_RESET;
            mask_q <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == ASC_ADDR_CONTROL) ctrl_q <= reg_wdata;
            if (reg_addr == ASC_ADDR_CLOCK_SEL) clk_q <= reg_wdata;
            if (reg_addr == ASC_ADDR_IRQ_MASK) mask_q <= reg_wdata[0];
        end
    end

    function automatic logic [3:0] lanes(input logic [2:0] cfg);
        return cfg[2] ? 4'hF : 4'((4'h1 << cfg[1:0]) - 4'h1);
    endfunction

    sequence s_rd(logic [7:0] a);
        reg_read && reg_addr == a;
    endsequence
    sequence s_cfg_wr;
        reg_write && reg_addr == ASC_ADDR_CONTROL;
    endsequence
    sequence s_start_rise;
        reg_write && reg_addr == ASC_ADDR_CONTROL
        && reg_wdata[ASC_START_BIT] && !ctrl_q[ASC_START_BIT];
    endsequence

    chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    chk_clk_readback: assert property (
        s_rd(ASC_ADDR_CLOCK_SEL) |=> reg_rdata == {clk_q[7], 5'h00, clk_q[1:0]})
        else $error("clock register readback wrong");
    chk_ctrl_readback: assert property (
        s_rd(ASC_ADDR_CONTROL) |=> reg_rdata[5:0] == ctrl_q[5:0])
        else $error("control register readback wrong");
    chk_low_pad: assert property (
        s_rd(ASC_ADDR_RESULT_LOW) |=> reg_rdata[6:0] == 7'h00)
        else $error("low result byte padding not zero");
    chk_power_lanes: assert property (
        converter_power == (port_b_analog != '0))
        else $error("converter power disagrees with analog lines");
    chk_pin_disable: assert property (
        port_b_digital_en == ~port_b_analog
        && port_b_pullup_en == ~port_b_analog)
        else $error("analog line keeps digital function");
    chk_lane_count: assert property (
        s_cfg_wr |-> ##2 port_b_analog == LINES'(lanes($past(ctrl_q[5:3]))))
        else $error("analog line count wrong");
    chk_chan_route: assert property (
        s_cfg_wr |-> ##2 analog_sel == $past(ctrl_q[1:0]))
        else $error("selected input wrong");
    chk_pending_set: assert property (
        s_start_rise ##[1:2] s_rd(ASC_ADDR_CONTROL)
        |=> reg_rdata[ASC_PENDING_BIT])
        else $error("pending flag not set by start");
    chk_irq_masked: assert property (
        !mask_q && !$past(mask_q) |-> !irq)
        else $error("interrupt while masked");
    chk_test_copy: assert property (
        $stable(clk_q[7]) |-> test_mode == clk_q[7])
        else $error("test output not following clock register");
endmodule

bind asc_top asc_chk #(.LINES(LINES)) chk_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .cmp_above(cmp_above), .analog_sel(analog_sel),
    .converter_power(converter_power), .port_b_analog(port_b_analog),
    .port_b_digital_en(port_b_digital_en),
    .port_b_pullup_en(port_b_pullup_en), .test_mode(test_mode), .irq(irq)
);

// ==== tb/asc_analog_model.sv ====
/* Analog front end: comparator decision for the selected input.
   Assumes each input sits fully above or below every trial value. */
`timescale 1ns/1ps
module asc_analog_model (
    input  wire logic       core_clk,
    input  wire logic       converter_power,
    input  wire logic [1:0] analog_sel,
    input  wire logic [3:0] level,
    output logic            cmp_above
);
    logic flip = 1'b0;

    always @(posedge core_clk) flip <= ~flip;
    // Powered-down comparator gives a changing pattern
    assign cmp_above = converter_power ? level[analog_sel] : flip;
endmodule

// ==== tb/asc_top_tb.sv ====
/* Self-checking bench for asc_top with the analog input model.
   Assumes the bench is the only register master; one 25 MHz clock. */
`timescale 1ns/1ps
module asc_top_tb
    import asc_pkg::*;
;
    logic        core_clk  = 1'b0;
    logic        rst       = 1'b1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read  = 1'b0;
    logic [3:0]  level     = 4'h0;
    logic [7:0]  reg_rdata;
    logic        cmp_above;
    logic        converter_power;
    logic        test_mode;
    logic        irq;
    logic [1:0]  analog_sel;
    logic [3:0]  port_b_analog;
    logic [3:0]  port_b_digital_en;
    logic [3:0]  port_b_pullup_en;
    logic [15:0] d;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc       = 0;

    asc_top dut_u (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .cmp_above(cmp_above),
        .analog_sel(analog_sel), .converter_power(converter_power),
        .port_b_analog(port_b_analog), .port_b_digital_en(port_b_digital_en),
        .port_b_pullup_en(port_b_pullup_en), .test_mode(test_mode),
        .irq(irq)
    );
    asc_analog_model model_u (
        .core_clk(core_clk), .converter_power(converter_power),
        .analog_sel(analog_sel), .level(level), .cmp_above(cmp_above)
    );

    always #20 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 d = 16'(reg_rdata);
    endtask

    task automatic t_regs();
        rd(ASC_ADDR_CONTROL);
        check("control reset", d, 16'(ASC_CONTROL_RESET));
        rd(ASC_ADDR_CLOCK_SEL);
        check("clock reset", d, 16'(ASC_CLOCK_SEL_RESET));
        wr(ASC_ADDR_CLOCK_SEL, 8'hFF);
        rd(ASC_ADDR_CLOCK_SEL);
        check("clock unused bits", d, 16'h0083);
        check("test output", 16'(test_mode), 16'h0001);
        wr(ASC_ADDR_CLOCK_SEL, 8'h00);
        wr(8'h3C, 8'hFF);
        rd(8'h3C);
        check("unmapped read", d, 16'h0000);
        $display("register test done");
    endtask

    task automatic t_pins();
        logic [3:0] ln;
        logic [3:0] dn;
        for (int c = 0; c < 8; c++) begin
            ln = (c > 3) ? 4'hF : 4'((1 << c) - 1);
            dn = ~ln;
            wr(ASC_ADDR_CONTROL, 8'((c << 3) | (c & 3)));
            repeat (2) @(posedge core_clk);
            #1;
            check("analog lines", 16'(port_b_analog), 16'(ln));
            check("power", 16'(converter_power), 16'(c != 0));
            check("digital en", 16'(port_b_digital_en), 16'(dn));
            check("pull-up en", 16'(port_b_pullup_en), 16'(dn));
            check("route", 16'(analog_sel), 16'(c & 3));
        end
        $display("pin test done");
    endtask

    task automatic convert(logic [1:0] div, logic [1:0] ch);
        logic [8:0] res;
        int         t0;
        int         lim;
        res = level[ch] ? 9'h1FF : 9'h000;
        lim = (div == 2'h0) ? 2 : (div == 2'h1) ? 8 : 32;
        wr(ASC_ADDR_IRQ_STATUS, 8'h01);
        wr(ASC_ADDR_CLOCK_SEL, {6'h00, div});
        wr(ASC_ADDR_CONTROL, {5'h04, 1'b0, ch});
        wr(ASC_ADDR_CONTROL, {5'h14, 1'b0, ch});
        rd(ASC_ADDR_CONTROL);
        check("pending set", 16'(d[6]), 16'h0001);
        wr(ASC_ADDR_CONTROL, {5'h04, 1'b0, ch});
        #1 t0 = cyc;
        do rd(ASC_ADDR_CONTROL); while (d[6] && cyc - t0 < 400);
        check("pending clear", 16'(d[6]), 16'h0000);
        check("time low", 16'(cyc - t0 >= 8 * lim), 16'h0001);
        check("time high", 16'(cyc - t0 <= 9 * lim + 8), 16'h0001);
        rd(ASC_ADDR_RESULT_HIGH);
        check("result high", d, 16'(res[8:1]));
        rd(ASC_ADDR_RESULT_LOW);
        check("result low", d, 16'({res[0], 7'h00}));
        rd(ASC_ADDR_IRQ_STATUS);
        check("request", 16'(d[0]), 16'h0001);
    endtask

    task automatic t_conv();
        level = 4'b0101;
        for (int i = 0; i < 4; i++) begin
            convert(2'(i % 3), 2'(i));
        end
        $display("conversion test done");
    endtask

    task automatic t_irq();
        wr(ASC_ADDR_IRQ_STATUS, 8'h01);
        wr(ASC_ADDR_IRQ_MASK, 8'h01);
        convert(2'h0, 2'h0);
        check("irq raised", 16'(irq), 16'h0001);
        wr(ASC_ADDR_IRQ_MASK, 8'h00);
        @(posedge core_clk);
        #1 check("irq masked", 16'(irq), 16'h0000);
        wr(ASC_ADDR_IRQ_MASK, 8'h01);
        @(posedge core_clk);
        #1 check("irq unmasked", 16'(irq), 16'h0001);
        wr(ASC_ADDR_IRQ_STATUS, 8'h01);
        @(posedge core_clk);
        #1 check("irq cleared", 16'(irq), 16'h0000);
        wr(ASC_ADDR_CONTROL, 8'h60);
        rd(ASC_ADDR_CONTROL);
        check("flag not writable", 16'(d[6]), 16'h0000);
        $display("interrupt test done");
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_regs();
        t_pins();
        t_conv();
        t_irq();
        end_sim();
    end
endmodule
